/* File: ddr3_cfg_timing.sv */
// DDR3 controller configuration, refresh and command spacing block
`include "ddr3_cfg_regs.svh"
`default_nettype none

module ddr3_cfg_timing (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_avs_response_err,
  input  wire logic        i_mem_clk_en,
  input  wire logic [2:0]  i_cmd,
  input  wire logic [2:0]  i_cmd_bank,
  input  wire logic        i_cmd_rank,
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  output logic             o_refresh_req,
  input  wire logic        i_refresh_ack,
  output logic             o_init_busy,
  output logic             o_init_start,
  output logic [2:0]       o_term_code,
  output logic [1:0]       o_write_termination_strength,
  output logic             o_write_term_reserved,
  output logic [4:0]       o_write_latency,
  output logic [6:0]       o_bus_width_bits,
  output logic [4:0]       o_read_latency,
  output logic             o_read_latency_reserved,
  output logic [3:0]       o_bank_count,
  output logic             o_chip_select_0,
  output logic             o_chip_select_1,
  output logic [3:0]       o_column_bits,
  output logic [11:0]      o_page_words
);

  logic [31:0] memory_config_reg;
  logic [31:0] refresh_control_reg;
  logic [31:0] timing_set_one_reg;
  logic        ack_reg;
  logic [31:0] wmask;
  logic [31:0] wdata_masked;
  logic        wr_cfg;
  logic        init_trigger;
  ddr3_cfg_pkg::init_state_t init_state_reg;
  logic [15:0] init_cnt_reg;
  logic [15:0] refresh_cnt_reg;
  logic        refresh_pend_reg;
  logic [7:0]  wr_pre_cnt_reg;
  logic [7:0]  wtr_cnt_reg;
  logic [7:0]  rrd_cnt_reg;
  logic [7:0]  ras_cnt_reg [`BANK_CNT];
  logic [8:0]  rc_cnt_reg  [`BANK_CNT];
  logic [`BANK_CNT-1:0] bank_ok;
  logic        cmd_ok;
  logic        cmd_fire;
  logic        init_off;

  assign init_off = refresh_control_reg[`INIT_OFF_BIT];

  // Byte enables to bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
    end
  end
  assign wdata_masked = i_avs_writedata & wmask;

  // Avalon slave answers one cycle after the request
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end

  // Writes commit at the completing edge, when waitrequest is low
  assign wr_cfg = i_avs_write & ack_reg & (i_avs_address == `MEMORY_CONFIG_OFFSET);
  // Initialization starts on a config write enabling byte lane 0 or 1 while init_off is clear
  assign init_trigger = wr_cfg & (i_avs_byteenable[0] | i_avs_byteenable[1]);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      memory_config_reg   <= `MEMORY_CONFIG_RESET;
      refresh_control_reg <= `REFRESH_CONTROL_RESET;
      timing_set_one_reg  <= `TIMING_SET_ONE_RESET;
    end else if (i_avs_write && ack_reg) begin
      case (i_avs_address)
        `MEMORY_CONFIG_OFFSET: begin
          memory_config_reg <= (memory_config_reg & ~(wmask & `MEMORY_CONFIG_MASK))
                             | (wdata_masked & `MEMORY_CONFIG_MASK);
        end
        `REFRESH_CONTROL_OFFSET: begin
          refresh_control_reg <= (refresh_control_reg & ~(wmask & `REFRESH_CONTROL_MASK))
                               | (wdata_masked & `REFRESH_CONTROL_MASK);
        end
        `TIMING_SET_ONE_OFFSET: begin
          timing_set_one_reg <= (timing_set_one_reg & ~(wmask & `TIMING_SET_ONE_MASK))
                              | (wdata_masked & `TIMING_SET_ONE_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // Read data and error answer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata     <= 32'h0000_0000;
      o_avs_response_err <= 1'b0;
    end else if ((i_avs_read || i_avs_write) && !ack_reg) begin
      o_avs_response_err <= (i_avs_address > `CONTROL_STATUS_OFFSET);
      case (i_avs_address)
        `MEMORY_CONFIG_OFFSET:   o_avs_readdata <= memory_config_reg;
        `REFRESH_CONTROL_OFFSET: o_avs_readdata <= refresh_control_reg;
        `TIMING_SET_ONE_OFFSET:  o_avs_readdata <= timing_set_one_reg;
        `CONTROL_STATUS_OFFSET:  o_avs_readdata <= {29'h0000_0000, refresh_pend_reg,
                                   memory_config_reg[`MEM_TYPE_LSB +: 3] == `MEM_TYPE_DDR3,
                                   o_init_busy};
        default:                 o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Initialization sequencer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      init_state_reg <= ddr3_cfg_pkg::INIT_IDLE;
      init_cnt_reg   <= 16'h0000;
    end else begin
      case (init_state_reg)
        ddr3_cfg_pkg::INIT_IDLE: begin
          if (!init_off) begin
            init_state_reg <= ddr3_cfg_pkg::INIT_RUN;
            init_cnt_reg   <= `INIT_CYCLES;
          end
        end
        ddr3_cfg_pkg::INIT_RUN: begin
          if (init_off) begin
            init_state_reg <= ddr3_cfg_pkg::INIT_DONE;
          end else if (i_mem_clk_en) begin
            if (init_cnt_reg == 16'h0000) begin
              init_state_reg <= ddr3_cfg_pkg::INIT_DONE;
            end else begin
              init_cnt_reg <= init_cnt_reg - 16'h0001;
            end
          end
        end
        ddr3_cfg_pkg::INIT_DONE: begin
          if (init_trigger && !init_off) begin
            init_state_reg <= ddr3_cfg_pkg::INIT_RUN;
            init_cnt_reg   <= `INIT_CYCLES;
          end
        end
        default: init_state_reg <= ddr3_cfg_pkg::INIT_IDLE;
      endcase
    end
  end
  assign o_init_busy  = (init_state_reg == ddr3_cfg_pkg::INIT_RUN);
  assign o_init_start = init_trigger & ~init_off;

  // Refresh interval timer; request set wins over acknowledge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refresh_cnt_reg  <= 16'h0000;
      refresh_pend_reg <= 1'b0;
    end else if (init_off) begin
      refresh_cnt_reg  <= 16'h0000;
      refresh_pend_reg <= 1'b0;
    end else if (i_mem_clk_en) begin
      if (({1'b0, refresh_cnt_reg} + 17'h0_0001) >= {1'b0, refresh_control_reg[15:0]}) begin
        refresh_cnt_reg  <= 16'h0000;
        refresh_pend_reg <= 1'b1;
      end else begin
        refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
        if (i_refresh_ack) begin
          refresh_pend_reg <= 1'b0;
        end
      end
    end else if (i_refresh_ack) begin
      refresh_pend_reg <= 1'b0;
    end
  end
  assign o_refresh_req = refresh_pend_reg & ~o_init_busy;

  // Per-bank activate spacing counters
  genvar g;
  generate
    for (g = 0; g < `BANK_CNT; g++) begin : g_bank
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          ras_cnt_reg[g] <= 8'h00;
          rc_cnt_reg[g]  <= 9'h000;
        end else if (cmd_fire && i_cmd == ddr3_cfg_pkg::CMD_ACT && i_cmd_bank == 3'(g)) begin
          ras_cnt_reg[g] <= {1'b0, timing_set_one_reg[`T_RAS_LSB +: 7]} + 8'h01;
          rc_cnt_reg[g]  <= {1'b0, timing_set_one_reg[`T_RC_LSB +: 8]} + 9'h001;
        end else if (i_mem_clk_en) begin
          if (ras_cnt_reg[g] != 8'h00) ras_cnt_reg[g] <= ras_cnt_reg[g] - 8'h01;
          if (rc_cnt_reg[g] != 9'h000) rc_cnt_reg[g] <= rc_cnt_reg[g] - 9'h001;
        end
      end
      assign bank_ok[g] = (i_cmd == ddr3_cfg_pkg::CMD_ACT) ? (rc_cnt_reg[g] == 9'h000) :
                          (i_cmd == ddr3_cfg_pkg::CMD_PRE) ? (ras_cnt_reg[g] == 8'h00) : 1'b1;
    end
  endgenerate

  // Shared spacing counters
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pre_cnt_reg <= 8'h00;
      wtr_cnt_reg    <= 8'h00;
      rrd_cnt_reg    <= 8'h00;
    end else begin
      if (cmd_fire && i_cmd == ddr3_cfg_pkg::CMD_WR) begin
        wr_pre_cnt_reg <= {3'h0, timing_set_one_reg[`T_WR_LSB +: 5]} + 8'h01;
        wtr_cnt_reg    <= {4'h0, timing_set_one_reg[`WRITE_TO_READ_GAP_LSB +: 4]} + 8'h01;
      end else if (i_mem_clk_en) begin
        if (wr_pre_cnt_reg != 8'h00) wr_pre_cnt_reg <= wr_pre_cnt_reg - 8'h01;
        if (wtr_cnt_reg != 8'h00) wtr_cnt_reg <= wtr_cnt_reg - 8'h01;
      end
      if (cmd_fire && i_cmd == ddr3_cfg_pkg::CMD_ACT) begin
        rrd_cnt_reg <= {2'h0, timing_set_one_reg[`ACT_TO_ACT_DIFF_BANK_LSB +: 6]} + 8'h01;
      end else if (i_mem_clk_en && rrd_cnt_reg != 8'h00) begin
        rrd_cnt_reg <= rrd_cnt_reg - 8'h01;
      end
    end
  end

  // Command gate
  always_comb begin
    cmd_ok = bank_ok[i_cmd_bank];
    case (i_cmd)
      ddr3_cfg_pkg::CMD_ACT: cmd_ok = cmd_ok & (rrd_cnt_reg == 8'h00);
      ddr3_cfg_pkg::CMD_PRE: cmd_ok = cmd_ok & (wr_pre_cnt_reg == 8'h00);
      ddr3_cfg_pkg::CMD_RD:  cmd_ok = cmd_ok & (wtr_cnt_reg == 8'h00);
      ddr3_cfg_pkg::CMD_REF: cmd_ok = cmd_ok & ~init_off;
      default:               cmd_ok = cmd_ok;
    endcase
  end
  assign o_cmd_ready = i_mem_clk_en & cmd_ok & ~o_init_busy;
  assign cmd_fire    = i_cmd_valid & o_cmd_ready;

  // Chip selects, active high decode
  assign o_chip_select_0 = cmd_fire & ~(memory_config_reg[`CS_BIT] & i_cmd_rank);
  assign o_chip_select_1 = cmd_fire & memory_config_reg[`CS_BIT] & i_cmd_rank;

  // Field decodes
  always_comb begin
    o_term_code = memory_config_reg[`TERM_LSB +: 3];
    o_write_termination_strength = memory_config_reg[`WR_TERM_LSB +: 2];
    o_write_term_reserved = (memory_config_reg[`WR_TERM_LSB +: 2] == 2'h3);
    o_write_latency = `WL_BASE + {2'h0, memory_config_reg[`WL_LSB +: 3]};
    case (memory_config_reg[`BUS_WIDTH_LSB +: 2])
      2'h0:    o_bus_width_bits = 7'd64;
      2'h1:    o_bus_width_bits = 7'd32;
      2'h2:    o_bus_width_bits = 7'd16;
      default: o_bus_width_bits = 7'd0;
    endcase
    o_read_latency_reserved = 1'b0;
    case (memory_config_reg[`RL_LSB +: 4])
      4'h2:    o_read_latency = 5'd5;
      4'h4:    o_read_latency = 5'd6;
      4'h6:    o_read_latency = 5'd7;
      4'h8:    o_read_latency = 5'd8;
      4'hA:    o_read_latency = 5'd9;
      4'hC:    o_read_latency = 5'd10;
      4'hE:    o_read_latency = 5'd11;
      4'h1:    o_read_latency = 5'd12;
      4'h3:    o_read_latency = 5'd13;
      4'h5:    o_read_latency = 5'd14;
      4'h7:    o_read_latency = 5'd15;
      4'h9:    o_read_latency = 5'd16;
      default: begin
        o_read_latency = 5'd0;
        o_read_latency_reserved = 1'b1;
      end
    endcase
    o_bank_count  = 4'h1 << memory_config_reg[`BANK_LSB +: 2];
    o_column_bits = 4'd8 + {2'h0, memory_config_reg[`COL_LSB +: 2]};
    o_page_words  = 12'h100 << memory_config_reg[`COL_LSB +: 2];
  end

endmodule
`default_nettype wire

/* File: ddr3_cfg_regs.svh */
// Register offsets, field positions and reset values of the configuration block
`ifndef DDR3_CFG_REGS_SVH
`define DDR3_CFG_REGS_SVH

`define MEMORY_CONFIG_OFFSET   4'h0
`define REFRESH_CONTROL_OFFSET 4'h1
`define TIMING_SET_ONE_OFFSET  4'h2
`define CONTROL_STATUS_OFFSET  4'h3

`define MEMORY_CONFIG_MASK     32'hEEC1_FF6B
`define REFRESH_CONTROL_MASK   32'h8000_FFFF
`define TIMING_SET_ONE_MASK    32'h3FFF_FFFF
`define MEMORY_CONFIG_RESET    32'h0000_0200
`define REFRESH_CONTROL_RESET  32'h0000_0C30
`define TIMING_SET_ONE_RESET   32'h3FFF_FFFF

`define MEM_TYPE_LSB           29
`define TERM_LSB               25
`define WR_TERM_LSB            22
`define WL_LSB                 14
`define BUS_WIDTH_LSB          12
`define RL_LSB                 8
`define BANK_LSB               5
`define CS_BIT                 3
`define COL_LSB                0
`define INIT_OFF_BIT           31
`define T_WR_LSB               25
`define T_RAS_LSB              18
`define T_RC_LSB               10
`define ACT_TO_ACT_DIFF_BANK_LSB              4
`define WRITE_TO_READ_GAP_LSB              0

`define MEM_TYPE_DDR3          3'h3
`define WL_BASE                5'h05
`define INIT_CYCLES            16'h0100
`define BANK_CNT               8

`endif

/* File: ddr3_cfg_pkg.sv */
// Types shared by the configuration and timing block
`default_nettype none
package ddr3_cfg_pkg;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF
  } mem_cmd_t;
  typedef enum logic [1:0] {
    INIT_IDLE, INIT_RUN, INIT_DONE
  } init_state_t;
endpackage
`default_nettype wire

/* File: ddr3_mem_model.sv */
// Memory-side partner: clock-enable pacing and refresh acknowledge
`default_nettype none
module ddr3_mem_model (
  input  wire logic i_clk,
  input  wire logic i_slow,
  input  wire logic i_refresh_req,
  output var  logic o_mem_clk_en,
  output var  logic o_refresh_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_reg = 2'h0;
  initial o_mem_clk_en = 1'b1;
  initial o_refresh_ack = 1'b0;
  // Slow mode: half-rate memory clock, late acknowledge
  always @(posedge i_clk) begin
    o_mem_clk_en <= i_slow ? ~o_mem_clk_en : 1'b1;
    wait_reg <= (i_refresh_req && !o_refresh_ack) ? wait_reg + 2'h1 : 2'h0;
    o_refresh_ack <= i_refresh_req && !o_refresh_ack && wait_reg == {i_slow, i_slow};
  end
endmodule
`default_nettype wire

/* File: ddr3_cfg_timing_assertions.sv */
// Port-level assertions of the configuration and timing block
`default_nettype none
module ddr3_cfg_timing_assertions (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_cmd_valid,
  input wire logic        i_cmd_rank,
  input wire logic        o_cmd_ready,
  input wire logic        o_chip_select_1,
  input wire logic        o_init_busy,
  input wire logic        o_init_start,
  input wire logic        o_refresh_req,
  input wire logic [4:0]  o_write_latency,
  input wire logic [4:0]  o_read_latency,
  input wire logic        o_read_latency_reserved,
  input wire logic [3:0]  o_column_bits,
  input wire logic [11:0] o_page_words
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  one_wait_a: assert property ($rose(i_avs_read || i_avs_write)
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus wait not one cycle");
  init_hold_a: assert property (o_init_busy |-> !o_cmd_ready)
    else $error("command ready during init");
  start_cause_a: assert property (o_init_start |-> i_avs_write && i_avs_address == 4'h0)
    else $error("init start without config write");
  refresh_gate_a: assert property (o_refresh_req |-> !o_init_busy)
    else $error("refresh during init");
  cs_route_a: assert property (o_chip_select_1 |-> i_cmd_valid && o_cmd_ready && i_cmd_rank)
    else $error("select 1 without rank 1 command");
  wl_range_a: assert property (o_write_latency >= 5'h05 && o_write_latency <= 5'h0C)
    else $error("write latency out of range");
  rl_range_a: assert property (!o_read_latency_reserved |-> o_read_latency inside {[5:16]})
    else $error("read latency out of range");
  page_col_a: assert property (o_page_words == (12'h100 << (o_column_bits - 4'h8)))
    else $error("page size and columns disagree");
  cover property (o_init_start);
  cover property (o_chip_select_1);
  cover property ($rose(o_refresh_req));
endmodule
bind ddr3_cfg_timing ddr3_cfg_timing_assertions i_chk (.i_clk, .i_reset_n, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_cmd_valid, .i_cmd_rank, .o_cmd_ready,
  .o_chip_select_1, .o_init_busy, .o_init_start, .o_refresh_req, .o_write_latency,
  .o_read_latency, .o_read_latency_reserved, .o_column_bits, .o_page_words);
`default_nettype wire

/* File: ddr3_cfg_timing_tb.sv */
// Self-checking bench of the configuration and timing block
`default_nettype none
module ddr3_cfg_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, err, waitreq, ready, cs0, cs1, busy, rreq, rack, clk_en, rl_res, e;
  logic        rst_n = 1'b0, rd = 1'b0, wr = 1'b0, valid = 1'b0, rank = 1'b0, slow = 1'b0;
  logic [3:0]  addr = 4'h0, banks, cols;
  logic [2:0]  op = 3'h0, bank = 3'h0, term;
  logic [31:0] wdata = 32'h0000_0000, rdata, q;
  logic [1:0]  wterm;
  logic [4:0]  wlat, rlat;
  logic [6:0]  width;
  logic [11:0] words;
  int          n_fail = 0, checked = 0, cyc = 0;
  ddr3_cfg_timing i_ddr3_cfg_timing (.i_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_avs_response_err(err),
    .i_mem_clk_en(clk_en), .i_cmd(op), .i_cmd_bank(bank), .i_cmd_rank(rank),
    .i_cmd_valid(valid), .o_cmd_ready(ready), .o_refresh_req(rreq), .i_refresh_ack(rack),
    .o_init_busy(busy), .o_init_start(), .o_term_code(term),
    .o_write_termination_strength(wterm), .o_write_term_reserved(), .o_write_latency(wlat),
    .o_bus_width_bits(width), .o_read_latency(rlat), .o_read_latency_reserved(rl_res),
    .o_bank_count(banks), .o_chip_select_0(cs0), .o_chip_select_1(cs1),
    .o_column_bits(cols), .o_page_words(words));
  ddr3_mem_model i_ddr3_mem_model (.i_clk(clk), .i_slow(slow), .i_refresh_req(rreq),
    .o_mem_clk_en(clk_en), .o_refresh_ack(rack));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic stop_test();
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic step(inout int n);
    @(negedge clk);
    n++;
    if (n > 3000) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do step(n); while (waitreq !== 1'b0);
    q = rdata;
    e = err;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic r, output int t);
    int n = 0;
    @(posedge clk);
    op <= c;
    bank <= b;
    rank <= r;
    valid <= 1'b1;
    do step(n); while (ready !== 1'b1);
    t = cyc;
    chk({cs1, cs0}, {r, !r}, "chip select");
    @(posedge clk);
    valid <= 1'b0;
  endtask
  task automatic reg_access();
    logic [31:0] rst_v [3] = '{32'h0000_0200, 32'h0000_0C30, 32'h3FFF_FFFF};
    logic [31:0] wr_v [3] = '{32'h7FFF_FFFF, 32'h7FFF_0C30, 32'hFFFF_FFFF};
    logic [31:0] rd_v [3] = '{32'h6EC1_FF6B, 32'h0000_0C30, 32'h3FFF_FFFF};
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 4'(i), 32'h0000_0000);
      chk(q, rst_v[i], "reset value");
      bus(1'b1, 4'(i), wr_v[i]);
      bus(1'b0, 4'(i), 32'h0000_0000);
      chk(q, rd_v[i], "reserved bits");
    end
    bus(1'b1, 4'h7, 32'hFFFF_FFFF);
    bus(1'b0, 4'h7, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped data");
    chk(e, 1'b1, "unmapped error");
  endtask
  task automatic decode_sweep();
    int n = 0;
    do step(n); while (busy !== 1'b0);
    for (int i = 1; i < 15; i++) begin
      bus(1'b1, 4'h0, {3'h3, 1'b0, 3'(i % 6), 1'b0, 2'(i % 3), 5'h00, 3'(i % 8), 2'(i % 3),
          4'(i), 1'b0, 2'(i % 4), 3'h0, 2'(i % 4)});
      @(negedge clk);
      chk(busy, 1'b1, "init start");
      chk(ready, 1'b0, "held off");
      chk(term, i % 6, "termination");
      chk(wterm, i % 3, "write termination");
      chk(wlat, 5 + i % 8, "write latency");
      chk(width, 64 >> (i % 3), "bus width");
      chk(rl_res, i == 11 || i == 13, "latency reserved");
      if (i != 11 && i != 13) chk(rlat, (i % 2) ? 12 + i / 2 : 4 + i / 2, "latency");
      chk(banks, 1 << (i % 4), "banks");
      chk({cols, words}, {4'(8 + i % 4), 12'(256 << (i % 4))}, "page");
    end
  endtask
  task automatic timing_gaps();
    int n = 0;
    int t [7];
    bus(1'b1, 4'h0, 32'h6000_0268);
    do step(n); while (busy !== 1'b0);
    bus(1'b1, 4'h2, {2'h0, 5'h02, 7'h03, 8'h05, 6'h02, 4'h1});
    cmd(3'h1, 3'h0, 1'b1, t[0]);
    cmd(3'h4, 3'h0, 1'b1, t[1]);
    chk(t[1] - t[0] >= 4, 1'b1, "act to pre");
    cmd(3'h1, 3'h0, 1'b0, t[2]);
    chk(t[2] - t[0] >= 6, 1'b1, "act to act");
    cmd(3'h1, 3'h1, 1'b0, t[3]);
    chk(t[3] - t[2] >= 3, 1'b1, "act other bank");
    cmd(3'h3, 3'h1, 1'b1, t[4]);
    cmd(3'h2, 3'h1, 1'b0, t[5]);
    chk(t[5] - t[4] >= 2, 1'b1, "write to read");
    cmd(3'h4, 3'h1, 1'b0, t[6]);
    chk(t[6] - t[4] >= 3, 1'b1, "write to pre");
  endtask
  task automatic refresh_test();
    int n = 0;
    int t;
    bus(1'b1, 4'h1, 32'h8000_0020);
    bus(1'b1, 4'h0, 32'h6000_0268);
    @(negedge clk);
    chk(busy, 1'b0, "init off");
    repeat (300) @(negedge clk) n += (rreq !== 1'b0);
    chk(n, 0, "refresh off");
    cmd(3'h2, 3'h0, 1'b0, t);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      bus(1'b1, 4'h1, 32'h0000_0020);
      repeat (100) @(negedge clk);
      n = 0;
      repeat (1000) @(negedge clk) n += (rack === 1'b1);
      chk(n >= (s ? 14 : 29) && n <= (s ? 17 : 32), 1'b1, "refresh rate");
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_access();
    decode_sweep();
    timing_gaps();
    refresh_test();
    stop_test();
  end
endmodule
`default_nettype wire
